//--- common/sarseq_pkg.sv
package sarseq_pkg;

    // ********************************
    // Register addresses
    // ********************************
    localparam logic [15:0] ADDR_DIR = 16'hff22;
    localparam logic [15:0] ADDR_LATCH = 16'hff02;
    localparam logic [15:0] ADDR_APC = 16'hff8f;
    localparam logic [15:0] ADDR_MODE = 16'hff28;
    localparam logic [15:0] ADDR_CHAN = 16'hff29;
    localparam logic [15:0] ADDR_RES_LO = 16'hff1e;
    localparam logic [15:0] ADDR_RES_HI = 16'hff1f;
    localparam logic [15:0] ADDR_RES_BYTE = 16'hff2a;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [3:0] APC_RST = 4'h8;
    localparam logic [15:0] RES_WORD_RST = 16'h0000;
    localparam logic [7:0] RES_BYTE_RST = 8'h00;

    // ********************************
    // Field positions
    // ********************************
    localparam int MODE_CE = 0;
    localparam int MODE_TS_LO = 1;
    localparam int MODE_TS_HI = 6;
    localparam int MODE_RUN = 7;
    localparam int CHAN_W = 3;
    localparam int ADC_BITS = 10;
    localparam int RES_SHIFT = 6;
    localparam logic [9:0] TAP_HALF = 10'h200;

    // ********************************
    // Conversion timing, in core cycles
    // ********************************
    localparam int TMR_W = 8;
    localparam logic [7:0] SAMPLE_UNIT = 8'h04;
    localparam logic [7:0] TRIAL_UNIT = 8'h04;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_TRIAL
    } sarseq_state_t;

endpackage

//--- design/sarseq_timer.sv
`timescale 1ns/1ps
module sarseq_timer #(
    parameter int W = sarseq_pkg::TMR_W
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    output logic done_o
);
    import sarseq_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
    } sarseq_tmr_st_t;

    sarseq_tmr_st_t st;
    sarseq_tmr_st_t next_st;

    // Load wins over counting so a phase restart never sees a stale expiry
    always_comb begin
        next_st = st;
        if (load_i) begin
            next_st.cnt = load_val_i;
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - W'(1);
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign done_o = (st.cnt == '0);

endmodule

//--- design/sarseq_pin_fn.sv
`timescale 1ns/1ps
module sarseq_pin_fn #(
    parameter int PIN_IDX = 0
) (
    input wire logic [3:0] apc_i,
    input wire logic [sarseq_pkg::CHAN_W-1:0] chan_i,
    input wire logic dir_i,
    input wire logic latch_i,
    input wire logic claim_i,
    output logic oe_n_o,
    output logic out_o,
    output logic analog_o,
    output logic conv_ok_o
);
    import sarseq_pkg::*;

    logic is_analog;
    logic is_sel;

    // Codes above eight are prohibited; they fall out as all digital
    assign is_analog = (apc_i <= 4'(PIN_IDX));
    assign is_sel = (chan_i == CHAN_W'(PIN_IDX));

    // Analog with output mode is prohibited; never drive in that case
    assign oe_n_o = dir_i | is_analog;
    assign out_o = latch_i;
    assign analog_o = is_analog & dir_i;
    assign conv_ok_o = is_analog & dir_i & is_sel & ~claim_i;

endmodule

//--- design/sarseq_top.sv
`timescale 1ns/1ps
// Operation
// - Direction bit 1 makes pin input, buffer off; 0 makes output, buffer on.
// - Reset sets the port direction register to all ones.
// - Analog input pins not selected stay unconverted; digital pins follow direction.
// - Selected analog input pin not claimed by sigma-delta gets converted.
// - Comparator enable bit powers the comparator so conversions can run.
// - Six time select bits set conversion timing.
// - Writing run bit 1 starts converting the selected channel.
// - Sample for a period set by time select bits 1:0, then hold until conversion ends.
// - First trial sets bit 9, tap at half reference, kept if at or above.
// - Next trial sets next bit; kept when input at or above tap.
// - After ten bits the value is latched into result registers, unless mode or APC is written in that cycle.
// - Done interrupt pulses in the same step as the latch.
// - Conversions repeat back to back while run bit stays 1.
// - Channel write aborts a conversion; restarts from sampling if running.
// - Result held in a 16-bit word and an 8-bit upper byte.
// - Reset clears both result registers.
// - Word result is the ten-bit value times sixty-four.
// - Select mode only: one of eight channels converted.
// - Three-bit channel code picks analog input 0 to 7.
// - Clearing run stops at once; last completed result is kept.
module sarseq_top (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [15:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic [7:0] pin_in_i,
    output logic [7:0] pin_out_o,
    output logic [7:0] pin_oe_n_o,
    output logic [7:0] pin_analog_o,
    input wire logic [7:0] sd_claim_i,
    input wire logic comp_i,
    output logic comp_power_o,
    output logic sample_hold_o,
    output logic [sarseq_pkg::CHAN_W-1:0] chan_sel_o,
    output logic [sarseq_pkg::ADC_BITS-1:0] tap_o,
    output logic comp_strobe_o,
    output logic busy_o,
    output logic conversion_done_irq_o
);
    import sarseq_pkg::*;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] latch;
        logic [3:0] apc;
        logic ce;
        logic [5:0] tsel;
        logic run;
        logic [CHAN_W-1:0] chan;
        sarseq_state_t state;
        logic [ADC_BITS-1:0] approximation_register;
        logic [3:0] bit_idx;
        logic [15:0] result_word;
        logic [7:0] result_byte;
        logic irq;
        logic strobe;
        logic [ADC_BITS-1:0] tap;
        logic sample_hold;
        logic busy;
        logic [7:0] rdata;
        logic [7:0] pin_oe_n;
        logic [7:0] pin_out;
        logic [7:0] pin_analog;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic comp1;
        logic comp2;
    } sarseq_top_st_t;

    sarseq_top_st_t st;
    sarseq_top_st_t next_st;

    logic [7:0] cell_oe_n;
    logic [7:0] cell_out;
    logic [7:0] cell_analog;
    logic [7:0] conv_ok;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic tmr_done;
    logic wr_dir;
    logic wr_latch;
    logic wr_apc;
    logic wr_mode;
    logic wr_chan;
    wire logic next_run = wr_mode ? sfr_wdata_i[MODE_RUN] : st.run;
    wire logic next_ce = wr_mode ? sfr_wdata_i[MODE_CE] : st.ce;
    wire logic [5:0] next_tsel = wr_mode ? sfr_wdata_i[MODE_TS_HI:MODE_TS_LO] : st.tsel;
    wire logic [CHAN_W-1:0] next_chan = wr_chan ? sfr_wdata_i[CHAN_W-1:0] : st.chan;
    logic run_ok;
    logic fin;
    logic [TMR_W-1:0] sample_len;
    logic [TMR_W-1:0] trial_len;

    // ********************************
    // Pin function per port pin
    // ********************************
    for (genvar g = 0; g < 8; g++) begin : g_pin
        sarseq_pin_fn #(
            .PIN_IDX(g)
        ) u_pin (
            .apc_i(st.apc),
            .chan_i(next_chan),
            .dir_i(st.dir[g]),
            .latch_i(st.latch[g]),
            .claim_i(sd_claim_i[g]),
            .oe_n_o(cell_oe_n[g]),
            .out_o(cell_out[g]),
            .analog_o(cell_analog[g]),
            .conv_ok_o(conv_ok[g])
        );
    end

    sarseq_timer #(
        .W(TMR_W)
    ) u_tmr (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .load_i(tmr_load),
        .load_val_i(tmr_val),
        .done_o(tmr_done)
    );

    // ********************************
    // Register decode
    // ********************************
    assign wr_dir = sfr_wr_i && (sfr_addr_i == ADDR_DIR);
    assign wr_latch = sfr_wr_i && (sfr_addr_i == ADDR_LATCH);
    assign wr_apc = sfr_wr_i && (sfr_addr_i == ADDR_APC);
    assign wr_mode = sfr_wr_i && (sfr_addr_i == ADDR_MODE);
    assign wr_chan = sfr_wr_i && (sfr_addr_i == ADDR_CHAN);

    // Level bits stretch sampling, frequency bits stretch every trial
    // Time bits written with the run bit already apply to that first conversion
    assign sample_len = TMR_W'(SAMPLE_UNIT * (8'(next_tsel[1:0]) + 8'h01));
    assign trial_len = TMR_W'(TRIAL_UNIT * (8'(next_tsel[5:2]) + 8'h01));
    // Current-cycle writes count so a stop, disable or new channel acts at once
    assign run_ok = next_run && next_ce && conv_ok[next_chan];
    assign fin = (st.state == ST_TRIAL) && tmr_done && (st.bit_idx == 4'h0);

    always_comb begin
        logic [ADC_BITS-1:0] decided;
        decided = st.approximation_register;
        next_st = st;
        next_st.strobe = 1'b0;
        next_st.irq = 1'b0;
        next_st.sync1 = pin_in_i;
        next_st.sync2 = st.sync1;
        next_st.comp1 = comp_i;
        next_st.comp2 = st.comp1;
        tmr_load = 1'b0;
        tmr_val = sample_len;

        if (wr_dir) begin
            next_st.dir = sfr_wdata_i;
        end
        if (wr_latch) begin
            next_st.latch = sfr_wdata_i;
        end
        if (wr_apc) begin
            next_st.apc = sfr_wdata_i[3:0];
        end
        if (wr_mode) begin
            next_st.ce = sfr_wdata_i[MODE_CE];
            next_st.tsel = sfr_wdata_i[MODE_TS_HI:MODE_TS_LO];
            next_st.run = sfr_wdata_i[MODE_RUN];
        end
        if (wr_chan) begin
            next_st.chan = sfr_wdata_i[CHAN_W-1:0];
        end

        // ********************************
        // Conversion sequencer
        // ********************************
        case (st.state)
            ST_IDLE: begin
                if (run_ok) begin
                    next_st.state = ST_SAMPLE;
                    tmr_load = 1'b1;
                end
            end
            ST_SAMPLE: begin
                if (!run_ok) begin
                    next_st.state = ST_IDLE;
                end else if (wr_chan) begin
                    tmr_load = 1'b1;
                end else if (tmr_done) begin
                    next_st.state = ST_TRIAL;
                    next_st.approximation_register = TAP_HALF;
                    next_st.tap = TAP_HALF;
                    next_st.bit_idx = 4'(ADC_BITS - 1);
                    next_st.strobe = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = trial_len;
                end
            end
            ST_TRIAL: begin
                if (!run_ok) begin
                    next_st.state = ST_IDLE;
                end else if (wr_chan) begin
                    next_st.state = ST_SAMPLE;
                    tmr_load = 1'b1;
                end else if (tmr_done) begin
                    // Comparator seen through its synchroniser, settled for a whole trial
                    if (!st.comp2) begin
                        decided[st.bit_idx] = 1'b0;
                    end
                    if (st.bit_idx == 4'h0) begin
                        // A control write in the finishing cycle drops the result
                        if (!(wr_mode || wr_apc)) begin
                            next_st.result_word = {decided, 6'h00};
                            next_st.result_byte = decided[ADC_BITS-1:2];
                            next_st.irq = 1'b1;
                        end
                        next_st.state = ST_SAMPLE;
                        tmr_load = 1'b1;
                    end else begin
                        decided[st.bit_idx - 4'h1] = 1'b1;
                        next_st.bit_idx = st.bit_idx - 4'h1;
                        next_st.strobe = 1'b1;
                        tmr_load = 1'b1;
                        tmr_val = trial_len;
                    end
                    next_st.approximation_register = decided;
                    next_st.tap = decided;
                end
            end
            default: begin
                next_st.state = ST_IDLE;
            end
        endcase

        next_st.busy = (next_st.state != ST_IDLE);
        next_st.sample_hold = (next_st.state == ST_SAMPLE);
        next_st.pin_oe_n = cell_oe_n;
        next_st.pin_out = cell_out;
        next_st.pin_analog = cell_analog;

        // Unmapped addresses and reserved bits read as zero
        next_st.rdata = 8'h00;
        if (sfr_rd_i) begin
            case (sfr_addr_i)
                ADDR_DIR: next_st.rdata = st.dir;
                ADDR_LATCH: next_st.rdata = (st.sync2 & st.dir & ~cell_analog) | (st.latch & ~st.dir);
                ADDR_APC: next_st.rdata = {4'h0, st.apc};
                ADDR_MODE: next_st.rdata = {st.run, st.tsel, st.ce};
                ADDR_CHAN: next_st.rdata = {5'h00, st.chan};
                ADDR_RES_LO: next_st.rdata = st.result_word[7:0];
                ADDR_RES_HI: next_st.rdata = st.result_word[15:8];
                ADDR_RES_BYTE: next_st.rdata = st.result_byte;
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= '0;
            st.dir <= DIR_RST;
            st.latch <= LATCH_RST;
            st.apc <= APC_RST;
            st.result_word <= RES_WORD_RST;
            st.result_byte <= RES_BYTE_RST;
            st.pin_oe_n <= 8'hff;
        end else begin
            st <= next_st;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign sfr_rdata_o = st.rdata;
    assign pin_out_o = st.pin_out;
    assign pin_oe_n_o = st.pin_oe_n;
    assign pin_analog_o = st.pin_analog;
    assign comp_power_o = st.ce;
    assign sample_hold_o = st.sample_hold;
    assign chan_sel_o = st.chan;
    assign tap_o = st.tap;
    assign comp_strobe_o = st.strobe;
    assign busy_o = st.busy;
    assign conversion_done_irq_o = st.irq;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_sample_to_trial;
        st.state == ST_SAMPLE ##1 st.state == ST_TRIAL;
    endsequence
    sequence s_step;
        st.state == ST_TRIAL && tmr_done && st.bit_idx != 4'h0 && run_ok && !wr_chan;
    endsequence
    dir_drive_a: assert property (st.dir[0] |=> pin_oe_n_o[0])
        else $error("input-mode pin is driven");
    dir_reset_a: assert property ($rose(nrst_i) |-> st.dir == DIR_RST)
        else $error("direction not all ones after reset");
    convert_gate_a: assert property (
        st.state == ST_IDLE && !conv_ok[st.chan] && !wr_chan && !wr_dir && !wr_apc
        |=> st.state == ST_IDLE)
        else $error("conversion started on unusable pin");
    comp_power_a: assert property (!st.ce && !wr_mode |=> !busy_o)
        else $error("conversion without comparator");
    hold_phase_a: assert property (st.state == ST_TRIAL |-> !sample_hold_o && busy_o)
        else $error("sample switch open during trials");
    msb_trial_a: assert property (s_sample_to_trial |-> tap_o == TAP_HALF && comp_strobe_o)
        else $error("first trial tap not half reference");
    bit_decide_a: assert property (s_step |=> st.approximation_register[$past(st.bit_idx)] == $past(st.comp2)
        && st.approximation_register[$past(st.bit_idx) - 4'h1] && comp_strobe_o)
        else $error("trial bit not decided by comparator");
    ten_bits_a: assert property (st.irq |-> $past(st.bit_idx) == 4'h0
        && $past(st.state) == ST_TRIAL)
        else $error("result latched before ten bits");
    done_irq_a: assert property ($changed(st.result_word) |-> st.irq)
        else $error("result latched without interrupt");
    repeat_a: assert property (fin && run_ok && !wr_chan |=> st.state == ST_SAMPLE ##1 sample_hold_o)
        else $error("no back to back conversion");
    abort_a: assert property (wr_chan && st.state != ST_IDLE && run_ok
        |=> st.state == ST_SAMPLE && $stable(st.result_word))
        else $error("channel write did not restart");
    byte_upper_a: assert property (st.result_byte == st.result_word[15:8])
        else $error("byte result not upper word bits");
    align_a: assert property (st.result_word[5:0] == 6'h00)
        else $error("word result not left aligned");
    stop_now_a: assert property (wr_mode && !sfr_wdata_i[MODE_RUN]
        |=> st.state == ST_IDLE && !busy_o ##1 $stable(st.result_word))
        else $error("run clear did not stop at once");

endmodule

//--- test/sarseq_analog_model.sv
`timescale 1ns/1ps
module sarseq_analog_model (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [79:0] level_i,
    input wire logic comp_power_i,
    input wire logic sample_hold_i,
    input wire logic [2:0] chan_sel_i,
    input wire logic [9:0] tap_i,
    output logic comp_o
);
    // ********************************
    // Sample and hold, comparator
    // ********************************
    logic [9:0] held;
    logic noise;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            held <= 10'h000;
            noise <= 1'b0;
        end else begin
            noise <= ~noise;
            if (sample_hold_i) begin
                held <= level_i[10 * int'(chan_sel_i) +: 10];
            end
        end
    end
    // Unpowered comparator gives garbage, never a stale answer
    assign comp_o = comp_power_i ? (held >= tap_i) : noise;
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import sarseq_pkg::*;
    // ********************************
    // Signals
    // ********************************
    logic core_clk_i;
    logic nrst_i;
    logic [15:0] sfr_addr_i;
    logic sfr_wr_i;
    logic sfr_rd_i;
    logic [7:0] sfr_wdata_i;
    logic [7:0] sfr_rdata_o;
    logic [7:0] pin_in_i;
    logic [7:0] pin_out_o;
    logic [7:0] pin_oe_n_o;
    logic [7:0] pin_analog_o;
    logic [7:0] sd_claim_i;
    logic comp_i;
    logic comp_power_o;
    logic sample_hold_o;
    logic [CHAN_W-1:0] chan_sel_o;
    logic [ADC_BITS-1:0] tap_o;
    logic comp_strobe_o;
    logic busy_o;
    logic conversion_done_irq_o;
    logic [79:0] levels;
    logic [9:0] lv;
    logic [3:0] frs [3] = '{4'h3, 4'hf, 4'h1};
    logic [1:0] lvs [3] = '{2'h2, 2'h3, 2'h0};
    int bad_count;
    int compares;
    int cycles;
    int sh_cnt;
    int sh_len;
    int st_cnt;
    int st_gap;
    int found;

    sarseq_top i_dut (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
        .pin_oe_n_o(pin_oe_n_o), .pin_analog_o(pin_analog_o), .sd_claim_i(sd_claim_i),
        .comp_i(comp_i), .comp_power_o(comp_power_o), .sample_hold_o(sample_hold_o),
        .chan_sel_o(chan_sel_o), .tap_o(tap_o), .comp_strobe_o(comp_strobe_o),
        .busy_o(busy_o), .conversion_done_irq_o(conversion_done_irq_o)
    );
    sarseq_analog_model i_analog (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .level_i(levels),
        .comp_power_i(comp_power_o), .sample_hold_i(sample_hold_o),
        .chan_sel_i(chan_sel_o), .tap_i(tap_o), .comp_o(comp_i)
    );

    // ********************************
    // Tasks
    // ********************************
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_write(input logic [15:0] addr, input logic [7:0] data);
        @(posedge core_clk_i);
        sfr_addr_i <= addr;
        sfr_wdata_i <= data;
        sfr_wr_i <= 1'b1;
        @(posedge core_clk_i);
        sfr_wr_i <= 1'b0;
    endtask
    task automatic reg_read(input logic [15:0] addr, input logic [7:0] exp, input string what);
        @(posedge core_clk_i);
        sfr_addr_i <= addr;
        sfr_rd_i <= 1'b1;
        @(posedge core_clk_i);
        sfr_rd_i <= 1'b0;
        #1;
        check_val({8'h00, sfr_rdata_o}, {8'h00, exp}, what);
    endtask
    // Bounded wait for a strobe (1) or a done pulse (0)
    task automatic wait_for(input bit strobe, input int limit);
        found = 0;
        repeat (limit) begin
            @(posedge core_clk_i);
            #1;
            if ((strobe ? comp_strobe_o : conversion_done_irq_o) === 1'b1) begin
                found = 1;
                break;
            end
        end
    endtask
    // Ideal comparator: the result equals the input code
    task automatic check_result(input int ch);
        lv = levels[ch * 10 +: 10];
        reg_read(ADDR_RES_LO, {lv[1:0], 6'h00}, "word low");
        reg_read(ADDR_RES_HI, lv[9:2], "word high");
        reg_read(ADDR_RES_BYTE, lv[9:2], "byte");
    endtask
    task automatic settle();
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask
    task automatic complete_run();
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ********************************
    // Clock, monitors, timeout
    // ********************************
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (sample_hold_o === 1'b1) begin
            sh_cnt <= sh_cnt + 1;
        end else if (sh_cnt != 0) begin
            sh_len <= sh_cnt;
            sh_cnt <= 0;
        end
        if (comp_strobe_o === 1'b1) begin
            st_gap <= st_cnt;
            st_cnt <= 1;
        end else begin
            st_cnt <= st_cnt + 1;
        end
        if (cycles >= 30000) begin
            bad_count++;
            complete_run();
        end
    end

    // ********************************
    // Tests
    // ********************************
    initial begin
        nrst_i = 1'b0;
        sfr_addr_i = 16'h0000;
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        sfr_wdata_i = 8'h00;
        pin_in_i = 8'h3c;
        sd_claim_i = 8'h00;
        levels = {10'h3fe, 10'h001, 10'h2aa, 10'h155, 10'h1ff, 10'h200, 10'h3ff, 10'h000};
        repeat (8) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        reg_read(ADDR_DIR, DIR_RST, "direction reset");
        check_result(0);
        reg_read(16'hff00, 8'h00, "unmapped read");
        check_val({8'h00, pin_oe_n_o}, 16'h00ff, "reset enables");
        reg_write(ADDR_DIR, 8'h0f);
        reg_write(ADDR_LATCH, 8'ha5);
        settle();
        check_val({8'h00, pin_oe_n_o}, 16'h000f, "output enables");
        check_val({8'h00, pin_out_o & 8'hf0}, 16'h00a0, "driven pins");
        reg_read(ADDR_LATCH, 8'hac, "port read");
        reg_write(ADDR_DIR, 8'hff);
        reg_write(ADDR_APC, 8'h00);
        reg_write(ADDR_MODE, 8'h01);
        settle();
        check_val({8'h00, pin_analog_o}, 16'h00ff, "analog pins");
        check_val({15'h0, comp_power_o}, 16'h0001, "comparator power");
        repeat (250) @(posedge core_clk_i);
        reg_write(ADDR_CHAN, 8'h00);
        reg_write(ADDR_MODE, 8'h81);
        wait_for(1'b1, 100);
        check_val(16'(found), 16'h1, "first strobe");
        check_val({6'h0, tap_o}, {6'h0, TAP_HALF}, "first tap");
        check_val({15'h0, sample_hold_o}, 16'h0, "hold in trial");
        check_val({15'h0, busy_o}, 16'h1, "busy in trial");
        wait_for(1'b0, 200);
        check_val(16'(found), 16'h1, "first done");
        check_result(0);
        for (int ch = 1; ch < 8; ch++) begin
            wait_for(1'b1, 200);
            reg_write(ADDR_CHAN, 8'(ch));
            wait_for(1'b0, 200);
            check_val(16'(found), 16'h1, "done after restart");
            check_val({13'h0, chan_sel_o}, 16'(ch), "channel out");
            check_result(ch);
            wait_for(1'b0, 200);
            check_val(16'(found), 16'h1, "repeat done");
            check_result(ch);
        end
        wait_for(1'b1, 200);
        reg_write(ADDR_MODE, 8'h01);
        settle();
        check_val({15'h0, busy_o}, 16'h0, "stopped");
        wait_for(1'b0, 150);
        check_val(16'(found), 16'h0, "no done when stopped");
        check_result(7);
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk_i);
            sd_claim_i <= (k == 0) ? 8'h80 : 8'h00;
            reg_write(ADDR_DIR, (k == 0) ? 8'hff : 8'h7f);
            reg_write(ADDR_MODE, 8'h81);
            wait_for(1'b0, 150);
            check_val(16'(found), 16'h0, "unusable pin converted");
            check_val({15'h0, busy_o}, 16'h0, "unusable pin busy");
            reg_write(ADDR_MODE, 8'h01);
        end
        reg_write(ADDR_DIR, 8'hff);
        for (int i = 0; i < 3; i++) begin
            reg_write(ADDR_MODE, {1'b1, frs[i], lvs[i], 1'b1});
            wait_for(1'b0, 1000);
            check_val(16'(found), 16'h1, "timed done");
            check_val(16'(sh_len), 16'(4 * (int'(lvs[i]) + 1) + 1), "sample length");
            check_val(16'(st_gap), 16'(4 * (int'(frs[i]) + 1) + 1), "trial length");
            check_result(7);
            reg_write(ADDR_MODE, 8'h01);
        end
        complete_run();
    end
endmodule
